// file: inc/bbsd_pkg.sv
// constants, types and carriers for the branch, bit-set and bit-test-skip decoder
//
// Overview of operation
// - opcode top five bits 11010 is the relative jump; low eleven bits are offset
// - jump offset is signed -1024..1023 and doubled to a byte offset
// - jump target is own address plus two plus twice offset; flags untouched
// - jump takes two cycles: decode, read, process, write counter; then a no-op
// - opcode top four bits 1000 is bit set: bit index, access selector, address
// - bit set forces chosen bit of register to one in one read-modify-write cycle
// - selector 0 uses the access bank; selector 1 uses the bank select pointer
// - extended set, selector 0, address at most 5Fh uses indexed literal offset
// - taken skip discards fetched word, runs one no-op cycle, two if double word
package bbsd_pkg;

   localparam int unsigned INSTR_W = 16;
   localparam int unsigned PC_W    = 21;
   localparam int unsigned FADDR_W = 12;
   localparam int unsigned OFF_W   = 11;
   localparam int unsigned BANK_W  = 4;

   // opcode patterns
   localparam logic [4:0] OPC_JUMP     = 5'h1A;
   localparam logic [3:0] OPC_SETBIT   = 4'h8;
   localparam logic [3:0] OPC_SKIP_CLR = 4'hB;
   localparam logic [3:0] OPC_SKIP_SET = 4'hA;

   // field positions
   localparam int unsigned BIT_LSB   = 9;
   localparam int unsigned ACC_POS   = 8;
   localparam int unsigned POL_POS   = 12;

   // addressing constants
   localparam logic [7:0]        IDX_LIMIT  = 8'h5F;
   localparam logic [7:0]        ACC_SPLIT  = 8'h80;
   localparam logic [BANK_W-1:0] ACC_HI_BNK = 4'hF;
   localparam logic [BANK_W-1:0] ACC_LO_BNK = 4'h0;
   localparam logic [PC_W-1:0]   PC_STEP    = 21'h000002;

   // no-op cycles after a jump or a skip
   localparam logic [1:0] NOP_ONE = 2'h1;
   localparam logic [1:0] NOP_TWO = 2'h2;

   typedef enum logic [1:0]
   {
      Q1 = 2'b00,
      Q2 = 2'b01,
      Q3 = 2'b11,
      Q4 = 2'b10
   } bbsd_quarter_e;

   typedef enum logic [1:0]
   {
      OP_NONE   = 2'b00,
      OP_JUMP   = 2'b01,
      OP_SETBIT = 2'b11,
      OP_SKIP   = 2'b10
   } bbsd_op_e;

   typedef struct packed
   {
      logic               rd;
      logic               wr;
      logic [FADDR_W-1:0] addr;
      logic [7:0]         wdata;
   } bbsd_file_s;

   typedef struct packed
   {
      logic            wr;
      logic [PC_W-1:0] target;
   } bbsd_pc_s;

endpackage

// file: logic/bbsd_decode.sv
// decoder and executor for relative jump, register bit set and bit test skip
`timescale 1ns/10ps
`default_nettype none

module bbsd_decode
   import bbsd_pkg::*;
(
   // clock and reset
   input  wire logic                 i_core_clk,
   input  wire logic                 i_rst_n,
   // fetched instruction
   input  wire logic [INSTR_W-1:0]   i_instr,
   input  wire logic [PC_W-1:0]      i_instr_addr,
   input  wire logic                 i_next_two_word,
   // addressing context
   input  wire logic                 i_ext_en,
   input  wire logic [BANK_W-1:0]    i_bank_select,
   input  wire logic [FADDR_W-1:0]   i_index_base,
   // file register read data
   input  wire logic [7:0]           i_rd_data,
   // sequencing
   output bbsd_quarter_e             o_quarter,
   output bbsd_op_e                  o_op,
   output var logic                  o_nop_cycle,
   output var logic                  o_flush,
   // file register and program counter
   output bbsd_file_s                o_file,
   output bbsd_pc_s                  o_pc
);

   //--------------------------------------------------------------
   // decode helpers
   //--------------------------------------------------------------
   function automatic bbsd_op_e decode_op(input logic [INSTR_W-1:0] ins);
      bbsd_op_e op;
      op = OP_NONE;
      if (ins[15:11] == OPC_JUMP)
         op = OP_JUMP;
      else if (ins[15:12] == OPC_SETBIT)
         op = OP_SETBIT;
      else if (ins[15:12] == OPC_SKIP_CLR || ins[15:12] == OPC_SKIP_SET)
         op = OP_SKIP;
      return op;
   endfunction

   function automatic logic [FADDR_W-1:0] resolve_addr(
      input logic [INSTR_W-1:0] ins,
      input logic               ext,
      input logic [BANK_W-1:0]  bank,
      input logic [FADDR_W-1:0] base);
      logic [7:0] f;
      f = ins[7:0];
      if (ins[ACC_POS])
         resolve_addr = {bank, f};
      else if (ext && f <= IDX_LIMIT)
         resolve_addr = FADDR_W'(base + {ACC_LO_BNK, f});
      else if (f >= ACC_SPLIT)
         resolve_addr = {ACC_HI_BNK, f};
      else
         resolve_addr = {ACC_LO_BNK, f};
   endfunction

   //--------------------------------------------------------------
   // state
   //--------------------------------------------------------------
   bbsd_quarter_e       q_r, q_nxt;
   bbsd_op_e            op_r, op_nxt;
   logic [INSTR_W-1:0]  instr_r, instr_nxt;
   logic [PC_W-1:0]     iaddr_r, iaddr_nxt;
   logic [7:0]          data_r, data_nxt;
   logic [1:0]          nop_r, nop_nxt;
   logic                nop_cyc_r, nop_cyc_nxt;
   logic                flush_r, flush_nxt;
   bbsd_file_s          file_r, file_nxt;
   bbsd_pc_s            pc_r, pc_nxt;

   logic [PC_W-1:0]     jump_target;
   logic [7:0]          bit_mask;
   logic                skip_taken;

   // offset doubled and sign extended onto the counter width
   assign jump_target = PC_W'(iaddr_r + PC_STEP
                        + {{(PC_W-OFF_W-1){instr_r[OFF_W-1]}},
                           instr_r[OFF_W-1:0], 1'b0});
   assign bit_mask    = 8'(8'h01 << instr_r[BIT_LSB+:3]);
   // clear variant skips on zero, set variant on one
   assign skip_taken  = instr_r[POL_POS] ? ~|(data_r & bit_mask)
                                         : |(data_r & bit_mask);

   //--------------------------------------------------------------
   // next-state logic
   //--------------------------------------------------------------
   always_comb
   begin
      q_nxt        = q_r;
      op_nxt       = op_r;
      instr_nxt    = instr_r;
      iaddr_nxt    = iaddr_r;
      data_nxt     = data_r;
      nop_nxt      = nop_r;
      nop_cyc_nxt  = nop_cyc_r;
      flush_nxt    = 1'b0;
      file_nxt     = file_r;
      file_nxt.rd  = 1'b0;
      file_nxt.wr  = 1'b0;
      pc_nxt       = pc_r;
      pc_nxt.wr    = 1'b0;
      unique case (q_r)
         Q1:
         begin
            q_nxt = Q2;
            if (nop_r != 2'h0)
            begin
               // fetched word is discarded; this cycle does nothing
               op_nxt      = OP_NONE;
               nop_nxt     = nop_r - 2'h1;
               nop_cyc_nxt = 1'b1;
            end
            else
            begin
               nop_cyc_nxt   = 1'b0;
               instr_nxt     = i_instr;
               iaddr_nxt     = i_instr_addr;
               op_nxt        = decode_op(i_instr);
               file_nxt.addr = resolve_addr(i_instr, i_ext_en, i_bank_select, i_index_base);
               file_nxt.rd   = (decode_op(i_instr) == OP_SETBIT)
                               || (decode_op(i_instr) == OP_SKIP);
            end
         end
         Q2:
         begin
            q_nxt = Q3;
            if (file_r.rd)
               data_nxt = i_rd_data;
         end
         Q3:
         begin
            q_nxt = Q4;
            if (op_r == OP_SETBIT)
            begin
               file_nxt.wr    = 1'b1;
               file_nxt.wdata = data_r | bit_mask;
            end
            else if (op_r == OP_JUMP)
            begin
               pc_nxt.wr     = 1'b1;
               pc_nxt.target = jump_target;
               nop_nxt       = NOP_ONE;
            end
            else if (op_r == OP_SKIP && skip_taken)
            begin
               flush_nxt = 1'b1;
               nop_nxt   = i_next_two_word ? NOP_TWO : NOP_ONE;
            end
         end
         Q4:
         begin
            q_nxt = Q1;
         end
      endcase
   end

   //--------------------------------------------------------------
   // registers
   //--------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         q_r       <= Q1;
         op_r      <= OP_NONE;
         instr_r   <= 16'h0000;
         iaddr_r   <= 21'h000000;
         data_r    <= 8'h00;
         nop_r     <= 2'h0;
         nop_cyc_r <= 1'b0;
         flush_r   <= 1'b0;
         file_r    <= '0;
         pc_r      <= '0;
      end
      else
      begin
         q_r       <= q_nxt;
         op_r      <= op_nxt;
         instr_r   <= instr_nxt;
         iaddr_r   <= iaddr_nxt;
         data_r    <= data_nxt;
         nop_r     <= nop_nxt;
         nop_cyc_r <= nop_cyc_nxt;
         flush_r   <= flush_nxt;
         file_r    <= file_nxt;
         pc_r      <= pc_nxt;
      end
   end

   assign o_quarter   = q_r;
   assign o_op        = op_r;
   assign o_nop_cycle = nop_cyc_r;
   assign o_flush     = flush_r;
   assign o_file      = file_r;
   assign o_pc        = pc_r;

   //--------------------------------------------------------------
   // assertions
   //--------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_jump_target: assert property (
      (q_r == Q3 && op_r == OP_JUMP) |=> (o_pc.wr && o_pc.target == jump_target))
      else $error("jump target or counter write wrong");

   a_jump_nop: assert property (
      o_pc.wr |-> ##2 (o_nop_cycle && o_op == OP_NONE) [*4])
      else $error("jump not followed by a no-op cycle");

   a_quarter_walk: assert property (
      (q_r == Q1) |=> (q_r == Q2) ##1 (q_r == Q3) ##1 (q_r == Q4))
      else $error("quarter sequence broken");

   a_setbit_read: assert property (
      (q_r == Q2 && op_r == OP_SETBIT) |-> o_file.rd)
      else $error("bit set did not read register");

   a_setbit_write: assert property (
      o_file.wr |-> (q_r == Q4 && op_r == OP_SETBIT
                     && o_file.wdata == (data_r | bit_mask)))
      else $error("bit set write wrong");

   a_setbit_flags: assert property (
      (op_r == OP_SETBIT) |-> (!o_pc.wr && !o_flush))
      else $error("bit set disturbed counter or skip");

   a_access_keep: assert property (
      (o_file.rd && !instr_r[ACC_POS] && instr_r[7:0] > IDX_LIMIT)
      |-> (o_file.addr == {(instr_r[7] ? ACC_HI_BNK : ACC_LO_BNK), instr_r[7:0]}))
      else $error("access bank address wrong");

   a_bank_addr: assert property (
      (o_file.rd && instr_r[ACC_POS])
      |-> (o_file.addr == {$past(i_bank_select), instr_r[7:0]}))
      else $error("bank select address wrong");

   a_index_addr: assert property (
      (o_file.rd && !instr_r[ACC_POS] && $past(i_ext_en) && instr_r[7:0] <= IDX_LIMIT)
      |-> (o_file.addr == FADDR_W'($past(i_index_base) + {ACC_LO_BNK, instr_r[7:0]})))
      else $error("indexed literal offset address wrong");

   a_skip_flush: assert property (
      o_flush |-> (op_r == OP_SKIP && skip_taken && q_r == Q4))
      else $error("flush without a taken skip");

   a_skip_nop: assert property (
      o_flush |-> (nop_r != 2'h0) ##2 o_nop_cycle)
      else $error("taken skip without a no-op cycle");

   a_decode_jump: assert property (
      (q_r == Q1 && nop_r == 2'h0 && i_instr[15:11] == OPC_JUMP) |=> (op_r == OP_JUMP))
      else $error("jump opcode not recognised");

endmodule

`default_nettype wire

// file: tb/tb_branch_bitset_skip_decode.sv
// self-checking testbench for the jump, bit set and bit test skip decoder
`timescale 1ns/10ps
`default_nettype none

module tb_branch_bitset_skip_decode
   import bbsd_pkg::*;
;
   logic                 i_core_clk;
   logic                 i_rst_n;
   logic [INSTR_W-1:0]   i_instr;
   logic [PC_W-1:0]      i_instr_addr;
   logic                 i_next_two_word;
   logic                 i_ext_en;
   logic [BANK_W-1:0]    i_bank_select;
   logic [FADDR_W-1:0]   i_index_base;
   logic [7:0]           i_rd_data;
   bbsd_quarter_e        o_quarter;
   bbsd_op_e             o_op;
   logic                 o_nop_cycle;
   logic                 o_flush;
   bbsd_file_s           o_file;
   bbsd_pc_s             o_pc;
   int                   fail_count = 0;
   int                   cmp_count  = 0;
   int                   cycles     = 0;

   bbsd_decode i_bbsd_decode (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_instr(i_instr),
      .i_instr_addr(i_instr_addr), .i_next_two_word(i_next_two_word), .i_ext_en(i_ext_en),
      .i_bank_select(i_bank_select), .i_index_base(i_index_base), .i_rd_data(i_rd_data),
      .o_quarter(o_quarter), .o_op(o_op), .o_nop_cycle(o_nop_cycle), .o_flush(o_flush),
      .o_file(o_file), .o_pc(o_pc));

   initial
   begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   always @(posedge i_core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fail_count++;
         summarize();
      end
   end

   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // one instruction cycle; pul = {rd in Q2, wr, counter write, flush in Q4}
   task automatic step(input logic [15:0] ins, input logic [20:0] pc, input logic [7:0] data,
                       input bbsd_op_e op, input logic nop, input logic [3:0] pul,
                       input logic [11:0] fa, input logic [7:0] wd);
      logic [20:0]   tgt;
      bbsd_quarter_e qs [4];
      tgt = pc + PC_STEP + {{9{ins[10]}}, ins[10:0], 1'b0};
      qs = '{Q2, Q3, Q4, Q1};
      i_instr      = ins;
      i_instr_addr = pc;
      i_rd_data    = data;
      for (int q = 0; q < 4; q++)
      begin
         @(posedge i_core_clk);
         #1;
         check(o_quarter, qs[q], "quarter");
         check(o_nop_cycle, nop, "no-op level");
         check(o_op, op, "operation");
         check({o_file.rd, o_file.wr, o_pc.wr, o_flush},
               (q == 0) ? (pul & 4'h8) : (q == 2) ? (pul & 4'h7) : 4'h0, "strobes");
         if (q == 0 && pul[3])
            check(o_file.addr, fa, "file address");
         if (q == 2 && pul[2])
            check(o_file.wdata, wd, "written data");
         if (q == 2 && pul[1])
            check(o_pc.target, tgt, "jump target");
      end
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_jump();
      logic [10:0] offs [4];
      offs = '{11'h3FF, 11'h400, 11'h7FF, 11'h001};
      for (int k = 0; k < 4; k++)
      begin
         step({5'h1A, offs[k]}, (k == 3) ? 21'h1FFFFE : 21'h000100, 8'h00, OP_JUMP, 1'b0,
              4'h2, 12'h000, 8'h00);
         step(16'h8F34, 21'h000102, 8'h00, OP_NONE, 1'b1, 4'h0, 12'h000, 8'h00);
      end
      step(16'hD800, 21'h000100, 8'h00, OP_NONE, 1'b0, 4'h0, 12'h000, 8'h00);
   endtask

   task automatic test_set_bit();
      logic [7:0]  fs  [5];
      logic        ext [5];
      logic [11:0] exp [5];
      fs  = '{8'h5F, 8'h60, 8'h80, 8'h10, 8'h20};
      ext = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      exp = '{12'h04F, 12'h060, 12'hF80, 12'h010, 12'h010};
      i_bank_select = 4'h5;
      i_index_base  = 12'hFF0;
      i_ext_en      = 1'b1;
      for (int b = 0; b < 8; b++)
         step({4'h8, b[2:0], 1'b1, 8'h34}, 21'h000200, 8'h0A, OP_SETBIT, 1'b0, 4'hC, 12'h534,
              8'h0A | (8'h01 << b));
      for (int k = 0; k < 5; k++)
      begin
         i_ext_en = ext[k];
         step({4'h8, 3'd7, 1'b0, fs[k]}, 21'h000200, 8'h7F, OP_SETBIT, 1'b0, 4'hC, exp[k],
              8'hFF);
      end
   endtask

   task automatic test_skip();
      step({4'hB, 3'd3, 1'b1, 8'h21}, 21'h000300, 8'hF7, OP_SKIP, 1'b0, 4'h9, 12'h521,
           8'h00);
      step(16'h8021, 21'h000302, 8'h00, OP_NONE, 1'b1, 4'h0, 12'h000, 8'h00);
      i_next_two_word = 1'b1;
      step({4'hA, 3'd6, 1'b1, 8'h21}, 21'h000304, 8'h40, OP_SKIP, 1'b0, 4'h9, 12'h521,
           8'h00);
      i_next_two_word = 1'b0;
      step(16'h8021, 21'h000306, 8'h00, OP_NONE, 1'b1, 4'h0, 12'h000, 8'h00);
      step(16'h8021, 21'h000308, 8'h00, OP_NONE, 1'b1, 4'h0, 12'h000, 8'h00);
      step({4'hB, 3'd3, 1'b1, 8'h21}, 21'h000310, 8'h08, OP_SKIP, 1'b0, 4'h8, 12'h521,
           8'h00);
      step({4'hA, 3'd0, 1'b1, 8'h21}, 21'h000312, 8'hFE, OP_SKIP, 1'b0, 4'h8, 12'h521,
           8'h00);
      step({4'h8, 3'd1, 1'b1, 8'h21}, 21'h000314, 8'h00, OP_SETBIT, 1'b0, 4'hC, 12'h521,
           8'h02);
   endtask

   // reset in the middle of a jump must drop the pending no-op cycle
   task automatic test_reset();
      // jump completes, so a no-op cycle is pending when reset hits in Q1
      step({5'h1A, 11'h010}, 21'h000400, 8'h00, OP_JUMP, 1'b0, 4'h2, 12'h000,
           8'h00);
      i_rst_n = 1'b0;
      #1;
      check(o_quarter, Q1, "quarter in reset");
      check(o_op, OP_NONE, "operation in reset");
      check(o_nop_cycle, 1'b0, "no-op level in reset");
      @(posedge i_core_clk);
      #1;
      i_rst_n = 1'b1;
      step({4'h8, 3'd4, 1'b1, 8'h01}, 21'h000400, 8'h00, OP_SETBIT, 1'b0, 4'hC, 12'h501,
           8'h10);
   endtask

   initial
   begin
      i_rst_n         = 1'b0;
      i_instr         = 16'h0000;
      i_instr_addr    = 21'h000000;
      i_next_two_word = 1'b0;
      i_ext_en        = 1'b0;
      i_bank_select   = 4'h0;
      i_index_base    = 12'h000;
      i_rd_data       = 8'h00;
      repeat (16) @(posedge i_core_clk);
      #1;
      i_rst_n = 1'b1;
      test_jump();
      test_set_bit();
      test_skip();
      test_reset();
      summarize();
   end
endmodule

`default_nettype wire
